// >>> hw/ldiap_params.svh
// Constants of the bus address and register pointer front end
// Summary of operation
// - Compare received address with seven strap pins.
// - Last address bit one reads, zero writes.
// - Reserved strap addresses treated as ordinary.
// - Broadcast address register resets to 1110000.
// - Broadcast matching enabled out of reset.
// - Subgroup address registers reset to defaults.
// - Subgroup matching disabled out of reset.
// - Soft reset address acknowledged only on write.
// - First write byte loads pointer control register.
// - Bits 4:0 pointer, bits 7:5 mode.
// - Pointer names first register accessed afterwards.
// - Top mode bit set steps pointer per byte.
// - Mode 000 keeps pointer fixed.
// - Mode 100 wraps 11h to 00h.
// - Mode 101 wraps 11h to 02h.
// - Mode 110 wraps 0Bh to 0Ah.
// - Mode 111 wraps 0Bh to 02h.
// - Stepping never alters the mode field.
// - Stepping continues every byte until transfer ends.
// - Pointer values above 11h are not acknowledged.
// - Mode register one enable bits gate groups.
`ifndef LDIAP_PARAMS_SVH
`define LDIAP_PARAMS_SVH
`define LDIAP_RST_CALL_ADDR 8'h06
`define LDIAP_BC_RST      8'hE0
`define LDIAP_SG1_RST     8'hE2
`define LDIAP_SG2_RST     8'hE4
`define LDIAP_SG3_RST     8'hE8
`define LDIAP_MREG_RST    5'h11
`define LDIAP_CTRL_RST    8'h80
`define LDIAP_REG_MREG    5'h00
`define LDIAP_REG_FIRST_BR 5'h02
`define LDIAP_REG_GRP_LO  5'h0A
`define LDIAP_REG_GRP_HI  5'h0B
`define LDIAP_REG_SG1     5'h0E
`define LDIAP_REG_SG2     5'h0F
`define LDIAP_REG_SG3     5'h10
`define LDIAP_REG_BC      5'h11
`define LDIAP_REG_LAST    5'h11
`define LDIAP_EN_SG1      3
`define LDIAP_EN_SG2      2
`define LDIAP_EN_SG3      1
`define LDIAP_EN_BC       0
`define LDIAP_BYTE_BITS   4'h8
`endif

// >>> hw/ldiap_pkg.sv
// Types of the bus address and register pointer front end
package ldiap_pkg;
    typedef enum logic [8:0] {
        LDIAP_IDLE = 9'h001,
        LDIAP_ADDR = 9'h002,
        LDIAP_AACK = 9'h004,
        LDIAP_CTRL = 9'h008,
        LDIAP_CACK = 9'h010,
        LDIAP_WDAT = 9'h020,
        LDIAP_WACK = 9'h040,
        LDIAP_RDAT = 9'h080,
        LDIAP_RACK = 9'h100
    } ldiap_state_type;
    // Same layout as the control byte: mode 7:5, pointer 4:0
    typedef struct packed {
        logic [2:0] mode;
        logic [4:0] ptr;
    } ldiap_ptr_st_type;
endpackage

// >>> hw/ldiap_ptr_if.sv
// Pointer load and step signals between bus engine and pointer
`timescale 1ns/1ps
`default_nettype none
interface ldiap_ptr_if;
    logic       load;
    logic       step;
    logic [7:0] ctrl;
    logic [4:0] ptr;
    logic [2:0] mode;
    modport core (output load, step, ctrl, input ptr, mode);
    modport unit (input load, step, ctrl, output ptr, mode);
endinterface // ldiap_ptr_if
`default_nettype wire

// >>> hw/ldiap_sync.sv
// Three stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ldiap_sync import ldiap_pkg::*; #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] o;
    } ldiap_sync_st_type;
    ldiap_sync_st_type st_q;
    ldiap_sync_st_type st_d;

    // Shift chain; output follows once stages two and three agree
    always_comb begin
        st_d    = st_q;
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.o[i] = st_q.s3[i];
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign q = st_q.o;
endmodule // ldiap_sync
`default_nettype wire

// >>> hw/ldiap_pointer.sv
// Register pointer with mode dependent stepping and wrap
`timescale 1ns/1ps
`default_nettype none
`include "ldiap_params.svh"
module ldiap_pointer import ldiap_pkg::*; (
    input  wire logic  clock,
    input  wire logic  nrst,
    ldiap_ptr_if.unit  pif
);
    ldiap_ptr_st_type st_q;
    ldiap_ptr_st_type st_d;

    // Last register of a stepping window for a mode
    function automatic logic [4:0] last_of(input logic [2:0] m);
        return m[1] ? `LDIAP_REG_GRP_HI : `LDIAP_REG_LAST;
    endfunction

    // Wrap target of a stepping window for a mode
    function automatic logic [4:0] wrap_of(input logic [2:0] m);
        case (m)
            3'h5:    return `LDIAP_REG_FIRST_BR;
            3'h6:    return `LDIAP_REG_GRP_LO;
            3'h7:    return `LDIAP_REG_FIRST_BR;
            default: return 5'h00;
        endcase
    endfunction

    // Load from control byte or step within the window
    always_comb begin
        st_d = st_q;
        if (pif.load) begin
            st_d.ptr  = pif.ctrl[4:0];
            st_d.mode = pif.ctrl[7:5];
        end else if (pif.step && st_q.mode[2]) begin
            if (st_q.ptr >= last_of(st_q.mode)) begin
                st_d.ptr = wrap_of(st_q.mode);
            end else begin
                st_d.ptr = st_q.ptr + 5'h01;
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q <= ldiap_ptr_st_type'(`LDIAP_CTRL_RST);
        end else begin
            st_q <= st_d;
        end
    end
    assign pif.ptr  = st_q.ptr;
    assign pif.mode = st_q.mode;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    load_fields_a: assert property (pif.load |=> st_q == $past(pif.ctrl))
        else $error("control byte not loaded");
    fixed_mode_a: assert property (pif.step && !pif.load && st_q.mode == 3'h0 |=> $stable(st_q.ptr))
        else $error("pointer moved in mode 000");
    wrap_all_a: assert property (pif.step && !pif.load && st_q.mode == 3'h4 && st_q.ptr == 5'h11
        |=> st_q.ptr == 5'h00)
        else $error("mode 100 wrap wrong");
    wrap_bright_a: assert property (pif.step && !pif.load && st_q.mode == 3'h5 && st_q.ptr == 5'h11
        |=> st_q.ptr == 5'h02)
        else $error("mode 101 wrap wrong");
    wrap_group_a: assert property (pif.step && !pif.load && st_q.mode == 3'h6 && st_q.ptr == 5'h0B
        |=> st_q.ptr == 5'h0A)
        else $error("mode 110 wrap wrong");
    wrap_mixed_a: assert property (pif.step && !pif.load && st_q.mode == 3'h7 && st_q.ptr == 5'h0B
        |=> st_q.ptr == 5'h02)
        else $error("mode 111 wrap wrong");
    step_up_a: assert property (pif.step && !pif.load && st_q.mode[2] && st_q.ptr < 5'h0B
        |=> st_q.ptr == $past(st_q.ptr) + 5'h01)
        else $error("pointer did not step");
    mode_kept_a: assert property (!pif.load |=> $stable(st_q.mode))
        else $error("mode changed without load");
endmodule // ldiap_pointer
`default_nettype wire

// >>> hw/ldiap_top.sv
// Bus target front end: address decode, control byte, pointer
`timescale 1ns/1ps
`default_nettype none
`include "ldiap_params.svh"
module ldiap_top import ldiap_pkg::*; (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic [6:0] strap_address_pins,
    output logic            reg_wr_en,
    output logic [4:0]      reg_wr_addr,
    output logic [7:0]      reg_wdata,
    output logic [4:0]      reg_rd_addr,
    input  wire logic [7:0] reg_rdata,
    output logic            bus_soft_reset_call,
    output logic [4:0]      register_pointer,
    output logic [2:0]      increment_mode_field
);

    typedef struct packed {
        ldiap_state_type  st;
        logic [3:0]       cnt;
        logic [7:0]       sr;
        logic             dir;
        logic             rst_call;
        logic             oe_n;
        logic             scl_p;
        logic             sda_p;
        logic [7:0]       bc;
        logic [2:0][7:0]  sub;
        logic [4:0]       mreg;
        logic             wr;
        logic [4:0]       wadr;
        logic [7:0]       wdat;
        logic             srst;
    } ldiap_top_st_type;

    ldiap_top_st_type st_q;
    ldiap_top_st_type st_d;
    logic [8:0]       pins;
    logic             scl;
    logic             sda;
    logic [6:0]       strap;
    logic             rise;
    logic             fall;
    logic             start;
    logic             stop;
    logic             ahit;
    logic [7:0]       rd_byte;
    ldiap_ptr_if      pif ();

    // Address compare on the upper seven bits only
    function automatic logic hit7(input logic [7:0] a, input logic [7:0] b);
        return a[7:1] == b[7:1];
    endfunction

    // Pin synchronisers for clock, data and straps
    ldiap_sync #(.W(9)) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .d     ({scl_in, sda_in, strap_address_pins}),
        .q     (pins)
    );
    assign scl   = pins[8];
    assign sda   = pins[7];
    assign strap = pins[6:0];

    // Register pointer unit
    ldiap_pointer u_ptr (
        .clock (clock),
        .nrst  (nrst),
        .pif   (pif)
    );

    // Bus conditions from the filtered lines
    assign rise  = scl && !st_q.scl_p;
    assign fall  = !scl && st_q.scl_p;
    assign start = scl && st_q.scl_p && st_q.sda_p && !sda;
    assign stop  = scl && st_q.scl_p && !st_q.sda_p && sda;

    // Address match: straps, broadcast, subgroups, soft reset
    always_comb begin
        ahit = (st_q.sr[7:1] == strap);
        if (st_q.mreg[`LDIAP_EN_BC] && hit7(st_q.sr, st_q.bc)) begin
            ahit = 1'b1;
        end
        if (st_q.mreg[`LDIAP_EN_SG1] && hit7(st_q.sr, st_q.sub[0])) begin
            ahit = 1'b1;
        end
        if (st_q.mreg[`LDIAP_EN_SG2] && hit7(st_q.sr, st_q.sub[1])) begin
            ahit = 1'b1;
        end
        if (st_q.mreg[`LDIAP_EN_SG3] && hit7(st_q.sr, st_q.sub[2])) begin
            ahit = 1'b1;
        end
        if (st_q.sr == `LDIAP_RST_CALL_ADDR) begin
            ahit = 1'b1;
        end
    end

    // Read data: locally held registers, else the outside file
    always_comb begin
        case (pif.ptr)
            `LDIAP_REG_MREG: rd_byte = {pif.mode, st_q.mreg};
            `LDIAP_REG_SG1:  rd_byte = st_q.sub[0];
            `LDIAP_REG_SG2:  rd_byte = st_q.sub[1];
            `LDIAP_REG_SG3:  rd_byte = st_q.sub[2];
            `LDIAP_REG_BC:    rd_byte = st_q.bc;
            default:          rd_byte = reg_rdata;
        endcase
    end

    // Bus engine
    always_comb begin
        st_d       = st_q;
        st_d.scl_p = scl;
        st_d.sda_p = sda;
        st_d.wr    = 1'b0;
        st_d.srst  = 1'b0;
        pif.load   = 1'b0;
        pif.step   = 1'b0;
        pif.ctrl   = st_q.sr;
        if (start) begin
            st_d.st   = LDIAP_ADDR;
            st_d.cnt  = 4'h0;
            st_d.oe_n = 1'b1;
        end else if (stop) begin
            st_d.st   = LDIAP_IDLE;
            st_d.oe_n = 1'b1;
        end else begin
            case (st_q.st)
                LDIAP_IDLE: begin
                    st_d.oe_n = 1'b1;
                end
                LDIAP_ADDR, LDIAP_CTRL, LDIAP_WDAT: begin
                    if (rise) begin
                        st_d.sr  = {st_q.sr[6:0], sda};
                        st_d.cnt = st_q.cnt + 4'h1;
                    end
                    if (fall && st_q.cnt == `LDIAP_BYTE_BITS) begin
                        st_d.st = LDIAP_IDLE;
                        if (st_q.st == LDIAP_ADDR && ahit) begin
                            st_d.st    = LDIAP_AACK;
                            st_d.oe_n  = 1'b0;
                            st_d.dir   = st_q.sr[0];
                            st_d.rst_call = (st_q.sr == `LDIAP_RST_CALL_ADDR);
                        end
                        if (st_q.st == LDIAP_CTRL && st_q.sr[4:0] <= `LDIAP_REG_LAST) begin
                            st_d.st   = LDIAP_CACK;
                            st_d.oe_n = 1'b0;
                            pif.load  = 1'b1;
                        end
                        if (st_q.st == LDIAP_WDAT) begin
                            st_d.st   = LDIAP_WACK;
                            st_d.oe_n = 1'b0;
                            st_d.wr   = 1'b1;
                            st_d.wadr = pif.ptr;
                            st_d.wdat = st_q.sr;
                            case (pif.ptr)
                                `LDIAP_REG_MREG: st_d.mreg   = st_q.sr[4:0];
                                `LDIAP_REG_SG1:  st_d.sub[0] = st_q.sr;
                                `LDIAP_REG_SG2:  st_d.sub[1] = st_q.sr;
                                `LDIAP_REG_SG3:  st_d.sub[2] = st_q.sr;
                                `LDIAP_REG_BC:    st_d.bc     = st_q.sr;
                                default:          st_d.wr     = 1'b1;
                            endcase
                        end
                    end
                end
                LDIAP_AACK: begin
                    if (fall) begin
                        st_d.oe_n = 1'b1;
                        st_d.cnt  = 4'h0;
                        if (st_q.rst_call) begin
                            st_d.srst = 1'b1;
                            st_d.st   = LDIAP_IDLE;
                        end else if (st_q.dir) begin
                            st_d.st   = LDIAP_RDAT;
                            st_d.sr   = rd_byte;
                            st_d.oe_n = rd_byte[7];
                            st_d.cnt  = 4'h1;
                        end else begin
                            st_d.st = LDIAP_CTRL;
                        end
                    end
                end
                LDIAP_CACK: begin
                    if (fall) begin
                        st_d.oe_n = 1'b1;
                        st_d.cnt  = 4'h0;
                        st_d.st   = LDIAP_WDAT;
                    end
                end
                LDIAP_WACK: begin
                    if (fall) begin
                        st_d.oe_n = 1'b1;
                        st_d.cnt  = 4'h0;
                        st_d.st   = LDIAP_WDAT;
                        pif.step  = 1'b1;
                    end
                end
                LDIAP_RDAT: begin
                    if (fall) begin
                        if (st_q.cnt == `LDIAP_BYTE_BITS) begin
                            st_d.oe_n = 1'b1;
                            st_d.st   = LDIAP_RACK;
                            pif.step  = 1'b1;
                        end else begin
                            st_d.sr   = {st_q.sr[6:0], 1'b0};
                            st_d.oe_n = st_q.sr[6];
                            st_d.cnt  = st_q.cnt + 4'h1;
                        end
                    end
                end
                LDIAP_RACK: begin
                    if (rise) begin
                        st_d.dir = ~sda;
                    end
                    if (fall) begin
                        if (st_q.dir) begin
                            st_d.st   = LDIAP_RDAT;
                            st_d.sr   = rd_byte;
                            st_d.oe_n = rd_byte[7];
                            st_d.cnt  = 4'h1;
                        end else begin
                            st_d.st = LDIAP_IDLE;
                        end
                    end
                end
                default: begin
                    st_d.st   = LDIAP_IDLE;
                    st_d.oe_n = 1'b1;
                end
            endcase
        end
    end

    // State register with volatile address reset values
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q        <= '0;
            st_q.st     <= LDIAP_IDLE;
            st_q.oe_n   <= 1'b1;
            st_q.scl_p  <= 1'b1;
            st_q.sda_p  <= 1'b1;
            st_q.bc     <= `LDIAP_BC_RST;
            st_q.sub[0] <= `LDIAP_SG1_RST;
            st_q.sub[1] <= `LDIAP_SG2_RST;
            st_q.sub[2] <= `LDIAP_SG3_RST;
            st_q.mreg   <= `LDIAP_MREG_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs
    assign sda_out              = 1'b0;
    assign sda_oe_n             = st_q.oe_n;
    assign reg_wr_en            = st_q.wr;
    assign reg_wr_addr          = st_q.wadr;
    assign reg_wdata            = st_q.wdat;
    assign reg_rd_addr          = pif.ptr;
    assign bus_soft_reset_call  = st_q.srst;
    assign register_pointer     = pif.ptr;
    assign increment_mode_field = pif.mode;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence addr_done;
        st_q.st == LDIAP_ADDR && fall && !start && !stop && st_q.cnt == 4'h8;
    endsequence
    sequence ctrl_done;
        st_q.st == LDIAP_CTRL && fall && !start && !stop && st_q.cnt == 4'h8;
    endsequence

    own_addr_a: assert property (addr_done and (st_q.sr[7:1] == strap)
        |=> st_q.st == LDIAP_AACK && !sda_oe_n)
        else $error("own address not acknowledged");
    bc_ack_a: assert property (addr_done and (st_q.mreg[0] && st_q.sr[7:1] == st_q.bc[7:1])
        |=> st_q.st == LDIAP_AACK)
        else $error("broadcast address not acknowledged");
    sub_off_a: assert property (addr_done and (!ahit) |=> st_q.st == LDIAP_IDLE && sda_oe_n)
        else $error("unmatched address acknowledged");
    rst_call_ack_a: assert property (addr_done and (st_q.sr == 8'h06)
        |=> st_q.st == LDIAP_AACK ##1 (st_q.st == LDIAP_AACK)[*1])
        else $error("soft reset call not acknowledged");
    read_dir_a: assert property (st_q.st == LDIAP_AACK && fall && !start && !stop && st_q.dir && !st_q.rst_call
        |=> st_q.st == LDIAP_RDAT)
        else $error("read direction not taken");
    ctrl_load_a: assert property (ctrl_done and (st_q.sr[4:0] <= 5'h11)
        |=> st_q.st == LDIAP_CACK ##1 register_pointer == $past(st_q.sr[4:0], 2))
        else $error("control byte not stored");
    ptr_nack_a: assert property (ctrl_done and (st_q.sr[4:0] > 5'h11)
        |=> st_q.st == LDIAP_IDLE && sda_oe_n)
        else $error("reserved pointer acknowledged");
    bc_write_a: assert property ($changed(st_q.bc) |-> $past(st_q.st) == LDIAP_WDAT
        && $past(register_pointer) == 5'h11)
        else $error("broadcast address changed without write");
endmodule // ldiap_top
`default_nettype wire

// >>> testbench/ldiap_master_model.sv
// Bus controller model: start, stop and nine-bit byte slots
`timescale 1ns/1ps
`default_nettype none
module ldiap_master_model (
    input  wire logic clock,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // Idle bus: both lines released high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Wait whole clock periods, changes land after falling edges
    task automatic tk(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Start or repeated start; data falls while clock is high
    task automatic start();
        tk(6);
        sda_low = 1'b0;
        tk(4);
        scl = 1'b1;
        tk(4);
        sda_low = 1'b1;
        tk(4);
        scl = 1'b0;
    endtask
    // Stop: data rises while clock is high, clock then stands still
    task automatic stop();
        sda_low = 1'b1;
        tk(6);
        scl = 1'b1;
        tk(4);
        sda_low = 1'b0;
        tk(8);
    endtask
    // One bit of 16 clocks; data set in low phase, sampled mid high
    task automatic bit_x(input logic b, output logic r);
        tk(6);
        sda_low = ~b;
        tk(2);
        scl = 1'b1;
        tk(4);
        r = sda;
        tk(4);
        scl = 1'b0;
    endtask
    // Eight bits MSB first then acknowledge slot; FFh releases for reads
    task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r, output logic k);
        for (int i = 7; i >= 0; i--) begin
            bit_x(w[i], r[i]);
        end
        bit_x(a, k);
    endtask
endmodule // ldiap_master_model
`default_nettype wire

// >>> testbench/led_driver_i2c_address_pointer_tb.sv
// Testbench of the bus address and register pointer front end
`timescale 1ns/1ps
`default_nettype none
module led_driver_i2c_address_pointer_tb;
    import ldiap_pkg::*;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic [6:0]  strap = 7'h7C;
    wire logic   scl;
    wire logic   sda_low;
    wire logic   sda_w;
    logic        sda_out;
    logic        sda_oe_n;
    logic        reg_wr_en;
    logic [4:0]  reg_wr_addr;
    logic [7:0]  reg_wdata;
    logic [4:0]  reg_rd_addr;
    wire logic [7:0] reg_rdata;
    logic        bus_soft_reset_call;
    logic [4:0]  register_pointer;
    logic [2:0]  increment_mode_field;
    logic        srst_seen = 1'b0;
    logic [12:0] wq[$];
    int          fail_count = 0;
    int          check_count = 0;
    // Address byte and expected ack; own strap 7Ch is a reserved address
    localparam logic [8:0] AT[12] = '{9'h1F1, 9'h1F3, 9'h1C1, 9'h1C3, 9'h1C4, 9'h1C6,
                                      9'h1C8, 9'h1CA, 9'h1D0, 9'h1D2, 9'h00E, 9'h1E8};
    // Control byte and byte count of the stepping runs
    localparam logic [11:0] MT[6] = '{12'h053, 12'h903, 12'hB03, 12'hCA3, 12'hEA3, 12'hE49};
    always #5 clock = ~clock;
    // Open-drain data line with pull-up
    assign sda_w = (sda_oe_n ? 1'b1 : sda_out) & ~sda_low;
    assign reg_rdata = {3'h5, reg_rd_addr};
    // Record register writes and soft reset pulses
    always @(negedge clock) begin
        if (reg_wr_en === 1'b1) wq.push_back({reg_wr_addr, reg_wdata});
        if (bus_soft_reset_call === 1'b1) srst_seen <= 1'b1;
    end
    ldiap_master_model m_u (.clock(clock), .sda(sda_w), .scl(scl), .sda_low(sda_low));
    ldiap_top dut_u (
        .clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .strap_address_pins(strap), .reg_wr_en(reg_wr_en),
        .reg_wr_addr(reg_wr_addr), .reg_wdata(reg_wdata), .reg_rd_addr(reg_rd_addr),
        .reg_rdata(reg_rdata), .bus_soft_reset_call(bus_soft_reset_call),
        .register_pointer(register_pointer), .increment_mode_field(increment_mode_field)
    );
    // Expected pointer after one byte
    function automatic logic [4:0] nxt(input logic [4:0] p, input logic [2:0] m);
        case (m)
            3'h4: return (p == 5'h11) ? 5'h00 : p + 5'h01;
            3'h5: return (p == 5'h11) ? 5'h02 : p + 5'h01;
            3'h6: return (p == 5'h0B) ? 5'h0A : p + 5'h01;
            3'h7: return (p == 5'h0B) ? 5'h02 : p + 5'h01;
            default: return p;
        endcase
    endfunction
    // Compare and count
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
            fail_count++;
        end
    endtask
    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Start and address byte; e is the expected acknowledge
    task automatic addr(input logic [7:0] a, input logic e);
        logic [7:0] r;
        logic       k;
        m_u.start();
        m_u.xfer(a, 1'b1, r, k);
        chk({7'h0, k}, {7'h0, ~e});
    endtask
    task automatic wbyte(input logic [7:0] d, input logic e);
        logic [7:0] r;
        logic       k;
        m_u.xfer(d, 1'b1, r, k);
        chk({7'h0, k}, {7'h0, ~e});
    endtask
    // Read byte; l high gives the final not-acknowledge
    task automatic rbyte(input logic [7:0] e, input logic l);
        logic [7:0] r;
        logic       k;
        m_u.xfer(8'hFF, l, r, k);
        chk(r, e);
    endtask
    // Write transfer: control byte then n data bytes from d upward
    task automatic wseq(input logic [7:0] c, input int n, input logic [7:0] d);
        logic [4:0] p;
        p = c[4:0];
        wq.delete();
        addr(8'hF8, 1'b1);
        wbyte(c, 1'b1);
        for (int j = 0; j < n; j++) begin
            wbyte(d + 8'(j), 1'b1);
        end
        m_u.stop();
        for (int j = 0; j < n; j++) begin
            chk({3'h0, wq[j][12:8]}, {3'h0, p});
            chk(wq[j][7:0], d + 8'(j));
            p = nxt(p, c[7:5]);
        end
        chk({3'h0, register_pointer}, {3'h0, p});
        chk({5'h0, increment_mode_field}, {5'h0, c[7:5]});
    endtask
    // Hang guard
    initial begin
        repeat (40000) @(posedge clock);
        fail_count++;
        close_out();
    end
    // Main sequence
    initial begin
        logic [7:0] r;
        logic       k;
        repeat (10) @(negedge clock);
        nrst = 1'b1;
        repeat (8) @(negedge clock);
        chk({3'h0, register_pointer, increment_mode_field}, 8'h04);
        wseq(8'h8E, 0, 8'h00);
        addr(8'hF9, 1'b1);
        rbyte(8'hE2, 1'b0);
        rbyte(8'hE4, 1'b0);
        rbyte(8'hE8, 1'b0);
        rbyte(8'hE0, 1'b0);
        rbyte(8'h91, 1'b0);
        rbyte(8'hA1, 1'b1);
        m_u.stop();
        for (int i = 0; i < 12; i++) begin
            addr(AT[i][8:1], AT[i][0]);
            if (AT[i][1] & AT[i][0]) m_u.xfer(8'hFF, 1'b1, r, k);
            m_u.stop();
        end
        addr(8'hF8, 1'b1);
        wbyte(8'h92, 1'b0);
        m_u.stop();
        wseq(8'h00, 1, 8'h19);
        wseq(8'h0E, 1, 8'h45);
        addr(8'h44, 1'b1);
        m_u.stop();
        wseq(8'h00, 1, 8'h10);
        addr(8'hE0, 1'b0);
        m_u.stop();
        for (int i = 0; i < 6; i++) begin
            wseq(MT[i][11:4], int'(MT[i][3:0]), 8'h30);
        end
        addr(8'h30, 1'b1);
        m_u.stop();
        addr(8'h44, 1'b0);
        m_u.stop();
        addr(8'h06, 1'b1);
        m_u.stop();
        chk({7'h0, srst_seen}, 8'h01);
        close_out();
    end
endmodule // led_driver_i2c_address_pointer_tb
`default_nettype wire
